//--- core/sptrg_top.sv
`timescale 1ns/100ps
module sptrg_top #(
    parameter int TMO_MAX_CYC = sptrg_pkg::TMO_MAX_CYC
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic ACQ_CLK,
    input wire logic [sptrg_pkg::ANALOG_N-1:0] ANALOG_CH,
    input wire logic [sptrg_pkg::DIGITAL_N-1:0] DIGITAL_CH,
    input wire logic PROTOCOL_SELECT,
    input wire logic [sptrg_pkg::CHAN_W-1:0] SPI_CLOCK_SOURCE,
    input wire logic [sptrg_pkg::CHAN_W-1:0] SPI_MOSI_SOURCE,
    input wire logic [sptrg_pkg::CHAN_W-1:0] SPI_MISO_SOURCE,
    input wire logic [sptrg_pkg::CHAN_W-1:0] SPI_SELECT_SOURCE,
    input wire logic [sptrg_pkg::CHAN_W-1:0] SPI_INVERTED_SELECT_SOURCE,
    input wire logic [1:0] SPI_SELECT_TYPE,
    input wire logic SPI_LATCH_EDGE,
    input wire logic [sptrg_pkg::TMO_W-1:0] SPI_CLOCK_IDLE_TIMEOUT,
    input wire logic SPI_WATCHED_LINE_SELECT,
    input wire logic [sptrg_pkg::PAT_W-1:0] SPI_BIT_PATTERN_VALUE,
    input wire logic [sptrg_pkg::PAT_W-1:0] SPI_BIT_PATTERN_CARE,
    input wire logic [sptrg_pkg::LEN_W-1:0] SPI_PATTERN_LENGTH,
    input wire logic SPI_BIT_ORDER,
    input wire logic [sptrg_pkg::CHAN_W-1:0] UART_RECEIVE_SOURCE,
    input wire logic [sptrg_pkg::CHAN_W-1:0] UART_TRANSMIT_SOURCE,
    input wire logic UART_WATCHED_LINE_SELECT,
    input wire logic [1:0] UART_TRIGGER_CONDITION,
    input wire logic [1:0] UART_DATA_QUALIFIER,
    input wire logic [8:0] UART_MATCH_VALUE,
    input wire logic [sptrg_pkg::BAUD_W-1:0] UART_BIT_CYCLES,
    input wire logic [1:0] UART_PARITY,
    output logic TRIGGER,
    output logic SPI_WORD_ACTIVE,
    output logic UART_FRAME_BUSY
);
    localparam int CN = sptrg_pkg::CHAN_N;
    localparam int PW = sptrg_pkg::PAT_W;
    localparam int TW = sptrg_pkg::TMO_W;
    localparam int BW = sptrg_pkg::BAUD_W;
    localparam int LW = sptrg_pkg::LEN_W;

    function automatic logic chan_pick(input logic [CN-1:0] v,
                                       input logic [4:0] s);
        chan_pick = (int'(s) < CN) ? v[s] : 1'b0;
    endfunction

    // ****************************************
    // Acquisition domain sampling
    // ****************************************
    logic [1:0] acq_rst_ff;
    logic [CN-1:0] acq1_ff;
    logic [CN-1:0] acq2_ff;
    logic [CN-1:0] mc1_ff;
    logic [CN-1:0] mc2_ff;

    always_ff @(posedge ACQ_CLK or posedge RST) begin
        if (RST) begin
            acq_rst_ff <= 2'h3;
        end else begin
            acq_rst_ff <= {acq_rst_ff[0], 1'b0};
        end
    end

    always_ff @(posedge ACQ_CLK or posedge acq_rst_ff[1]) begin
        if (acq_rst_ff[1]) begin
            acq1_ff <= '0;
            acq2_ff <= '0;
        end else begin
            acq1_ff <= {DIGITAL_CH, ANALOG_CH};
            acq2_ff <= acq1_ff;
        end
    end

    // Each channel is an independent level, so a per-bit pair suffices
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            mc1_ff <= '0;
            mc2_ff <= '0;
        end else begin
            mc1_ff <= acq2_ff;
            mc2_ff <= mc1_ff;
        end
    end

    // ****************************************
    // SPI word capture
    // ****************************************
    logic sclk;
    logic sdat;
    logic ssel;
    logic [LW-1:0] len_c;
    logic [TW-1:0] tmo_c;
    logic sclk_prev_ff;
    logic [LW-1:0] cnt_ff;
    logic [PW-1:0] sr_ff;
    logic [TW-1:0] idle_ff;
    logic chk_ff;
    logic frame_ff;
    logic [LW-1:0] nxt_cnt;
    logic [PW-1:0] nxt_sr;
    logic [TW-1:0] nxt_idle;
    logic nxt_chk;
    logic nxt_frame;
    logic edge_any;
    logic edge_lat;
    logic word_end;
    logic [PW-1:0] word;
    logic [PW-1:0] lmask;
    logic spi_hit;

    always_comb begin
        sclk = chan_pick(mc2_ff, SPI_CLOCK_SOURCE);
        sdat = (SPI_WATCHED_LINE_SELECT == sptrg_pkg::LINE_MOSI) ?
            chan_pick(mc2_ff, SPI_MOSI_SOURCE) :
            chan_pick(mc2_ff, SPI_MISO_SOURCE);
        unique case (SPI_SELECT_TYPE)
            sptrg_pkg::SEL_INVERTED:
                ssel = !chan_pick(mc2_ff, SPI_INVERTED_SELECT_SOURCE);
            sptrg_pkg::SEL_TIMEOUT: ssel = 1'b1;
            default: ssel = chan_pick(mc2_ff, SPI_SELECT_SOURCE);
        endcase
        len_c = SPI_PATTERN_LENGTH;
        if (len_c < sptrg_pkg::LEN_MIN) begin
            len_c = sptrg_pkg::LEN_MIN;
        end else if (len_c > sptrg_pkg::LEN_MAX) begin
            len_c = sptrg_pkg::LEN_MAX;
        end
        tmo_c = SPI_CLOCK_IDLE_TIMEOUT;
        if (tmo_c < TW'(sptrg_pkg::TMO_MIN_CYC)) begin
            tmo_c = TW'(sptrg_pkg::TMO_MIN_CYC);
        end else if (tmo_c > TW'(TMO_MAX_CYC)) begin
            tmo_c = TW'(TMO_MAX_CYC);
        end
        edge_any = sclk != sclk_prev_ff;
        edge_lat = edge_any &&
            (sclk == (SPI_LATCH_EDGE == sptrg_pkg::EDGE_RISING));
        word_end = (SPI_SELECT_TYPE == sptrg_pkg::SEL_TIMEOUT) &&
            (idle_ff == tmo_c);
        nxt_idle = edge_any ? '0 :
            ((idle_ff == TW'(TMO_MAX_CYC)) ? idle_ff : idle_ff + 1'b1);
        nxt_cnt = cnt_ff;
        nxt_sr = sr_ff;
        nxt_chk = 1'b0;
        nxt_frame = ssel;
        if (!ssel || word_end) begin
            nxt_cnt = '0;
        end
        if (ssel && edge_lat && (word_end || cnt_ff < len_c)) begin
            nxt_sr = {sr_ff[PW-2:0], sdat};
            nxt_cnt = word_end ? LW'(1) : cnt_ff + 1'b1;
            nxt_chk = (nxt_cnt == len_c);
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            sclk_prev_ff <= 1'b0;
            cnt_ff <= '0;
            sr_ff <= '0;
            idle_ff <= '0;
            chk_ff <= 1'b0;
            frame_ff <= 1'b0;
        end else begin
            sclk_prev_ff <= sclk;
            cnt_ff <= nxt_cnt;
            sr_ff <= nxt_sr;
            idle_ff <= nxt_idle;
            chk_ff <= nxt_chk;
            frame_ff <= nxt_frame;
        end
    end

    // Newest bit sits in bit 0; MSB-first keeps the first bit at len-1
    always_comb begin
        word = '0;
        lmask = '0;
        for (int i = 0; i < PW; i++) begin
            lmask[i] = i < int'(len_c);
            if (SPI_BIT_ORDER == sptrg_pkg::ORDER_MSB) begin
                word[i] = sr_ff[i];
            end else if (i < int'(len_c)) begin
                word[i] = sr_ff[int'(len_c) - 1 - i];
            end
        end
        spi_hit = chk_ff && (((word ^ SPI_BIT_PATTERN_VALUE) &
            SPI_BIT_PATTERN_CARE & lmask) == '0);
    end

    // ****************************************
    // UART frame receiver
    // ****************************************
    logic uline;
    logic [BW-1:0] bit_c;
    sptrg_pkg::sptrg_uart_t ust_ff;
    sptrg_pkg::sptrg_uart_t nxt_ust;
    logic [BW-1:0] ucnt_ff;
    logic [BW-1:0] nxt_ucnt;
    logic [3:0] ubit_ff;
    logic [3:0] nxt_ubit;
    logic [sptrg_pkg::CHAR_W-1:0] ush_ff;
    logic [sptrg_pkg::CHAR_W-1:0] nxt_ush;
    logic upar_ff;
    logic nxt_upar;
    logic ev_start_ff;
    logic ev_stop_ff;
    logic ev_char_ff;
    logic ev_err_ff;
    logic nxt_start;
    logic nxt_stop;
    logic nxt_char;
    logic nxt_err;
    logic tick;

    always_comb begin
        uline = (UART_WATCHED_LINE_SELECT == sptrg_pkg::LINE_RX) ?
            chan_pick(mc2_ff, UART_RECEIVE_SOURCE) :
            chan_pick(mc2_ff, UART_TRANSMIT_SOURCE);
        bit_c = (UART_BIT_CYCLES == '0) ? BW'(1) : UART_BIT_CYCLES;
        tick = ucnt_ff == '0;
        nxt_ust = ust_ff;
        nxt_ucnt = tick ? bit_c - 1'b1 : ucnt_ff - 1'b1;
        nxt_ubit = ubit_ff;
        nxt_ush = ush_ff;
        nxt_upar = upar_ff;
        nxt_start = 1'b0;
        nxt_stop = 1'b0;
        nxt_char = 1'b0;
        nxt_err = 1'b0;
        unique case (ust_ff)
            sptrg_pkg::UART_IDLE: begin
                nxt_ucnt = bit_c >> 1;
                if (!uline) begin
                    nxt_ust = sptrg_pkg::UART_START;
                end
            end
            sptrg_pkg::UART_START: begin
                if (tick) begin
                    nxt_ust = uline ? sptrg_pkg::UART_IDLE :
                        sptrg_pkg::UART_DATA;
                    nxt_start = !uline;
                    nxt_ubit = '0;
                end
            end
            sptrg_pkg::UART_DATA: begin
                if (tick) begin
                    nxt_ush = {uline, ush_ff[sptrg_pkg::CHAR_W-1:1]};
                    nxt_ubit = ubit_ff + 1'b1;
                    if (ubit_ff == 4'(sptrg_pkg::CHAR_W - 1)) begin
                        nxt_ust = (UART_PARITY == sptrg_pkg::PAR_NONE) ?
                            sptrg_pkg::UART_STOP : sptrg_pkg::UART_PAR;
                    end
                end
            end
            sptrg_pkg::UART_PAR: begin
                if (tick) begin
                    nxt_upar = (^ush_ff ^ uline) !=
                        (UART_PARITY == sptrg_pkg::PAR_ODD);
                    nxt_ust = sptrg_pkg::UART_STOP;
                end
            end
            sptrg_pkg::UART_STOP: begin
                if (tick) begin
                    nxt_ust = sptrg_pkg::UART_IDLE;
                    nxt_ucnt = bit_c >> 1;
                    nxt_upar = 1'b0;
                    if (uline && !upar_ff) begin
                        nxt_stop = 1'b1;
                        nxt_char = 1'b1;
                    end else begin
                        nxt_err = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            ust_ff <= sptrg_pkg::UART_IDLE;
            ucnt_ff <= '0;
            ubit_ff <= '0;
            ush_ff <= '0;
            upar_ff <= 1'b0;
            ev_start_ff <= 1'b0;
            ev_stop_ff <= 1'b0;
            ev_char_ff <= 1'b0;
            ev_err_ff <= 1'b0;
        end else begin
            ust_ff <= nxt_ust;
            ucnt_ff <= nxt_ucnt;
            ubit_ff <= nxt_ubit;
            ush_ff <= nxt_ush;
            upar_ff <= nxt_upar;
            ev_start_ff <= nxt_start;
            ev_stop_ff <= nxt_stop;
            ev_char_ff <= nxt_char;
            ev_err_ff <= nxt_err;
        end
    end

    // ****************************************
    // Trigger decision
    // ****************************************
    logic qual_ok;
    logic uart_hit;
    logic trig_ff;
    logic busy_ff;
    logic nxt_trig;
    logic [8:0] chr9;

    always_comb begin
        chr9 = {1'b0, ush_ff};
        unique case (UART_DATA_QUALIFIER)
            sptrg_pkg::QUAL_MORE: qual_ok = chr9 > UART_MATCH_VALUE;
            sptrg_pkg::QUAL_LESS: qual_ok = chr9 < UART_MATCH_VALUE;
            default: qual_ok = chr9 == UART_MATCH_VALUE;
        endcase
        if (UART_MATCH_VALUE == sptrg_pkg::MATCH_ANY) begin
            qual_ok = 1'b1;
        end
        unique case (UART_TRIGGER_CONDITION)
            sptrg_pkg::COND_START: uart_hit = ev_start_ff;
            sptrg_pkg::COND_STOP: uart_hit = ev_stop_ff;
            sptrg_pkg::COND_DATA: uart_hit = ev_char_ff && qual_ok;
            default: uart_hit = ev_err_ff;
        endcase
        nxt_trig = (PROTOCOL_SELECT == sptrg_pkg::PROTO_SPI) ?
            spi_hit : uart_hit;
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            trig_ff <= 1'b0;
            busy_ff <= 1'b0;
        end else begin
            trig_ff <= nxt_trig;
            busy_ff <= nxt_ust != sptrg_pkg::UART_IDLE;
        end
    end

    assign TRIGGER = trig_ff;
    assign SPI_WORD_ACTIVE = frame_ff;
    assign UART_FRAME_BUSY = busy_ff;

    // ****************************************
    // Checks
    // ****************************************
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);

    trig_single_a: assert property (trig_ff |=> !trig_ff)
        else $error("trigger longer than one cycle");
    ncs_frame_a: assert property (
        SPI_SELECT_TYPE == sptrg_pkg::SEL_INVERTED &&
        chan_pick(mc2_ff, SPI_INVERTED_SELECT_SOURCE) |=> cnt_ff == '0)
        else $error("inverted select did not end word");
    spi_len_a: assert property (chk_ff |-> cnt_ff == len_c)
        else $error("compare not at pattern length");
    spi_dontcare_a: assert property (
        chk_ff && SPI_BIT_PATTERN_CARE == '0 && !PROTOCOL_SELECT
        |=> trig_ff)
        else $error("ignored pattern did not trigger");
    tmo_end_a: assert property (
        word_end |=> cnt_ff <= LW'(1))
        else $error("timeout did not end word");
    uart_any_a: assert property (
        ev_char_ff && PROTOCOL_SELECT &&
        UART_TRIGGER_CONDITION == sptrg_pkg::COND_DATA &&
        UART_MATCH_VALUE == sptrg_pkg::MATCH_ANY |=> trig_ff)
        else $error("any-value match missed");
    uart_start_a: assert property (
        $rose(ev_start_ff) && PROTOCOL_SELECT &&
        UART_TRIGGER_CONDITION == sptrg_pkg::COND_START |=> trig_ff)
        else $error("start condition missed");
    uart_err_a: assert property (
        ust_ff == sptrg_pkg::UART_STOP && tick && !uline
        |=> ev_err_ff ##1 (trig_ff ||
        !PROTOCOL_SELECT || UART_TRIGGER_CONDITION != sptrg_pkg::COND_ERROR))
        else $error("missing stop not reported");
    uart_busy_a: assert property (
        ust_ff == sptrg_pkg::UART_IDLE && !uline |=> ##1 busy_ff)
        else $error("start edge not followed");

    spi_trig_c: cover property (chk_ff && spi_hit ##1 trig_ff);
    uart_data_c: cover property (ev_char_ff && qual_ok && PROTOCOL_SELECT);
    uart_err_c: cover property (ev_err_ff);
    tmo_c_c: cover property (word_end && cnt_ff != '0);
endmodule

//--- core/sptrg_pkg.sv
package sptrg_pkg;
    // ****************************************
    // Channel selection
    // ****************************************
    localparam int CHAN_W = 5;
    localparam int ANALOG_N = 4;
    localparam int DIGITAL_N = 16;
    localparam int CHAN_N = ANALOG_N + DIGITAL_N;

    // ****************************************
    // SPI settings
    // ****************************************
    localparam int PAT_W = 96;
    localparam int LEN_W = 7;
    localparam logic [LEN_W-1:0] LEN_MIN = 7'h04;
    localparam logic [LEN_W-1:0] LEN_MAX = 7'h60;
    localparam logic [1:0] SEL_TRUE = 2'h0;
    localparam logic [1:0] SEL_INVERTED = 2'h1;
    localparam logic [1:0] SEL_TIMEOUT = 2'h2;
    localparam logic EDGE_RISING = 1'h0;
    localparam logic LINE_MOSI = 1'h0;
    localparam logic ORDER_MSB = 1'h0;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int TMO_MIN_NS = 100;
    localparam int TMO_MAX_NS = 5000000;
    localparam int TMO_MIN_CYC = (TMO_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMO_MAX_CYC = TMO_MAX_NS / CLK_PERIOD_NS;
    localparam int TMO_W = 18;

    // ****************************************
    // UART settings
    // ****************************************
    localparam int BAUD_W = 16;
    localparam int CHAR_W = 8;
    localparam logic [8:0] MATCH_ANY = 9'h100;
    localparam logic LINE_RX = 1'h0;
    localparam logic [1:0] COND_START = 2'h0;
    localparam logic [1:0] COND_STOP = 2'h1;
    localparam logic [1:0] COND_DATA = 2'h2;
    localparam logic [1:0] COND_ERROR = 2'h3;
    localparam logic [1:0] QUAL_EQUAL = 2'h0;
    localparam logic [1:0] QUAL_MORE = 2'h1;
    localparam logic [1:0] QUAL_LESS = 2'h2;
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ODD = 2'h1;
    localparam logic PROTO_SPI = 1'h0;

    typedef enum logic [4:0] {
        UART_IDLE = 5'h01,
        UART_START = 5'h02,
        UART_DATA = 5'h04,
        UART_PAR = 5'h08,
        UART_STOP = 5'h10
    } sptrg_uart_t;
endpackage

//--- dv/sptrg_bus_model.sv
`timescale 1ns/100ps
// ********
// Probed bus
// ********
module sptrg_bus_model #(
    parameter int HALF = 6,
    parameter int BIT = 20
) (
    input wire logic mclk,
    output logic [3:0] analog_ch,
    output logic [15:0] digital_ch
);
    // C1 tx, C2 inv select, D0 clk, D1 mosi, D2 miso, D3 select, D4 rx
    logic [19:0] chan = 20'h00103;
    assign analog_ch = chan[3:0];
    assign digital_ch = chan[19:4];

    // Fall timing moves data after the rising edge, so a wrong edge misaligns
    task automatic spi_word(input int n, input logic [95:0] mo,
            input logic [95:0] mi, input logic fall);
        @(posedge mclk);
        chan[7] <= 1'b1;
        chan[1] <= 1'b0;
        repeat (HALF) @(posedge mclk);
        for (int i = n - 1; i >= 0; i--) begin
            for (int s = 0; s < 3; s++) begin
                if (s == 2)
                    chan[4] <= 1'b0;
                else if ((s == 1) != fall)
                    chan[4] <= 1'b1;
                else
                    {chan[5], chan[6]} <= {mo[i], mi[i]};
                repeat (HALF) @(posedge mclk);
            end
        end
        chan[7] <= 1'b0;
        chan[1] <= 1'b1;
        {chan[5], chan[6]} <= ~{mo[i_last(n)], mi[i_last(n)]};
        repeat (HALF) @(posedge mclk);
    endtask

    function automatic int i_last(input int n);
        return 0;
    endfunction

    // Mode: bit0 parity sent, bit1 parity wrong, bit2 stop low
    task automatic uart_frame(input int line, input logic [7:0] d,
            input logic [2:0] mode);
        logic [10:0] bits;
        bits = mode[0] ? {~mode[2], ~^d ^ mode[1], d, 1'b0}
                       : {1'b1, ~mode[2], d, 1'b0};
        @(posedge mclk);
        for (int i = 0; i < 10 + mode[0]; i++) begin
            chan[line] <= bits[i];
            repeat (BIT) @(posedge mclk);
        end
        chan[line] <= 1'b1;
        repeat (2 * BIT) @(posedge mclk);
    endtask
endmodule

//--- dv/serial_protocol_trigger_tb.sv
`timescale 1ns/100ps
module serial_protocol_trigger_tb;
    localparam int LIMIT = 40000;
    logic mclk = 1'b0;
    logic acq_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] analog_ch;
    logic [15:0] digital_ch;
    logic prot = 1'b0;
    logic [4:0] sel_src = 5'h07;
    logic [1:0] sel_type = 2'h0;
    logic edge_sel = 1'b0;
    logic watch = 1'b0;
    logic [95:0] pat = 96'h0;
    logic [95:0] care = 96'h0;
    logic [6:0] len = 7'h08;
    logic order = 1'b0;
    logic uline = 1'b0;
    logic [1:0] cond = 2'h0;
    logic [1:0] qual = 2'h0;
    logic [1:0] par = 2'h0;
    logic [8:0] match = 9'h000;
    logic [4:0] inv_src = 5'h01;
    logic [4:0] rx_src = 5'h08;
    logic [4:0] tx_src = 5'h00;
    logic [17:0] tmo = 18'h0001E;
    logic [15:0] bit_cyc = 16'h0014;
    logic trigger;
    logic word_active;
    logic frame_busy;
    logic trig_d = 1'b0;
    int bad_count = 0;
    int compares = 0;
    int trig_seen = 0;
    int trig_mark = 0;
    int long_pulse = 0;
    int cycles = 0;
    // Qualifier, match value, character, expected pulses
    logic [27:0] dtab [7] = '{28'h0041411, 28'h0041420, 28'h1041421,
        28'h1041410, 28'h2041401, 28'h2041410, 28'h01007E1};

    initial forever #10 mclk = ~mclk;
    initial begin
        #7;
        forever #24 acq_clk = ~acq_clk;
    end

    sptrg_top #(.TMO_MAX_CYC(200)) dut (
        .MCLK(mclk), .RST(rst), .ACQ_CLK(acq_clk),
        .ANALOG_CH(analog_ch), .DIGITAL_CH(digital_ch),
        .PROTOCOL_SELECT(prot), .SPI_CLOCK_SOURCE(5'h04),
        .SPI_MOSI_SOURCE(5'h05), .SPI_MISO_SOURCE(5'h06),
        .SPI_SELECT_SOURCE(sel_src), .SPI_INVERTED_SELECT_SOURCE(inv_src),
        .SPI_SELECT_TYPE(sel_type), .SPI_LATCH_EDGE(edge_sel),
        .SPI_CLOCK_IDLE_TIMEOUT(tmo),
        .SPI_WATCHED_LINE_SELECT(watch), .SPI_BIT_PATTERN_VALUE(pat),
        .SPI_BIT_PATTERN_CARE(care), .SPI_PATTERN_LENGTH(len),
        .SPI_BIT_ORDER(order), .UART_RECEIVE_SOURCE(rx_src),
        .UART_TRANSMIT_SOURCE(tx_src), .UART_WATCHED_LINE_SELECT(uline),
        .UART_TRIGGER_CONDITION(cond), .UART_DATA_QUALIFIER(qual),
        .UART_MATCH_VALUE(match), .UART_BIT_CYCLES(bit_cyc),
        .UART_PARITY(par), .TRIGGER(trigger),
        .SPI_WORD_ACTIVE(word_active), .UART_FRAME_BUSY(frame_busy)
    );

    sptrg_bus_model bus (
        .mclk(mclk), .analog_ch(analog_ch), .digital_ch(digital_ch)
    );

    // ********
    // Checking
    // ********
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen,
            input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic expect_trig(input string name, input int exp);
        repeat (60) @(posedge mclk);
        check(name, 32'(trig_seen - trig_mark), 32'(exp));
        trig_mark = trig_seen;
    endtask

    task automatic spi_case(input int n, input logic [95:0] mo,
            input logic [95:0] mi, input logic fall, input int exp);
        bus.spi_word(n, mo, mi, fall);
        expect_trig("spi trigger", exp);
    endtask

    task automatic uart_case(input int line, input logic [7:0] d,
            input logic [2:0] mode, input int exp);
        bus.uart_frame(line, d, mode);
        expect_trig("uart trigger", exp);
    endtask

    always @(posedge mclk) begin
        trig_d <= trigger;
        if (trigger === 1'b1)
            trig_seen <= trig_seen + 1;
        if (trigger === 1'b1 && trig_d === 1'b1)
            long_pulse <= long_pulse + 1;
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            bad_count++;
            wrap_up();
        end
    end

    // ********
    // Tests
    // ********
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        repeat (10) @(posedge mclk);
        trig_mark = trig_seen;
        pat <= 96'hA5;
        care <= 96'hFF;
        spi_case(8, 96'hA5, 96'h0, 1'b0, 1);
        spi_case(8, 96'hA4, 96'h0, 1'b0, 0);
        spi_case(9, 96'h14B, 96'h0, 1'b0, 1);
        care <= 96'hFE;
        spi_case(8, 96'hA4, 96'h0, 1'b0, 1);
        check("word active", 32'(word_active), 32'h0);
        care <= 96'h0;
        spi_case(8, 96'h5A, 96'h0, 1'b0, 1);
        len <= 7'h04;
        pat <= 96'hB;
        care <= 96'hF;
        spi_case(4, 96'hB, 96'h0, 1'b0, 1);
        spi_case(4, 96'h3, 96'h0, 1'b0, 0);
        len <= 7'h60;
        pat <= 96'h0123456789ABCDEFF0E1D2C3;
        care <= ~96'h0;
        spi_case(96, 96'h0123456789ABCDEFF0E1D2C3, 96'h0, 1'b0, 1);
        spi_case(96, 96'h0123456789ABCDEFF0E1D2C2, 96'h0, 1'b0, 0);
        $display("done: spi pattern");
        len <= 7'h08;
        pat <= 96'hA0;
        care <= 96'hFF;
        order <= 1'b1;
        spi_case(8, 96'h05, 96'h0, 1'b0, 1);
        spi_case(8, 96'hA0, 96'h0, 1'b0, 0);
        order <= 1'b0;
        watch <= 1'b1;
        spi_case(8, 96'h5F, 96'hA0, 1'b0, 1);
        spi_case(8, 96'hA0, 96'h5F, 1'b0, 0);
        watch <= 1'b0;
        sel_src <= 5'h14;
        sel_type <= 2'h1;
        spi_case(8, 96'hA0, 96'h0, 1'b0, 1);
        sel_type <= 2'h0;
        spi_case(8, 96'hA0, 96'h0, 1'b0, 0);
        sel_src <= 5'h07;
        edge_sel <= 1'b1;
        spi_case(8, 96'hA0, 96'h0, 1'b1, 1);
        edge_sel <= 1'b0;
        spi_case(8, 96'hA0, 96'h0, 1'b1, 0);
        sel_type <= 2'h2;
        spi_case(8, 96'hA0, 96'h0, 1'b0, 1);
        spi_case(8, 96'hA4, 96'h0, 1'b0, 0);
        check("word active", 32'(word_active), 32'h1);
        $display("done: spi framing");
        prot <= 1'b1;
        qual <= 2'h2;
        uart_case(8, 8'h41, 3'h0, 1);
        cond <= 2'h1;
        uart_case(8, 8'h41, 3'h0, 1);
        cond <= 2'h3;
        uart_case(8, 8'h41, 3'h0, 0);
        uart_case(8, 8'h41, 3'h4, 1);
        par <= 2'h1;
        uart_case(8, 8'h41, 3'h3, 1);
        uart_case(8, 8'h41, 3'h1, 0);
        par <= 2'h2;
        uart_case(8, 8'h41, 3'h1, 1);
        uart_case(8, 8'h41, 3'h3, 0);
        par <= 2'h0;
        cond <= 2'h2;
        for (int i = 0; i < 7; i++) begin
            qual <= dtab[i][25:24];
            match <= dtab[i][20:12];
            uart_case(8, dtab[i][11:4], 3'h0, int'(dtab[i][0]));
        end
        cond <= 2'h0;
        rx_src <= 5'h01;
        uart_case(1, 8'h41, 3'h0, 1);
        rx_src <= 5'h08;
        uline <= 1'b1;
        uart_case(8, 8'h41, 3'h0, 0);
        uart_case(0, 8'h41, 3'h0, 1);
        check("frame busy", 32'(frame_busy), 32'h0);
        check("long pulses", 32'(long_pulse), 32'h0);
        $display("done: uart");
        wrap_up();
    end
endmodule
